// ===== hw/adc_seq_pkg.sv
package adc_seq_pkg;
    localparam int          DATA_W          = 32;
    localparam int          ADDR_W          = 8;
    // Register indices; the byte address is four times the index.
    localparam logic [5:0]  CTRL_ONE_IDX    = 6'h0e;
    localparam logic [5:0]  CTRL_TWO_IDX    = 6'h0f;
    localparam logic [5:0]  RESULT_IDX      = 6'h20;
    localparam logic [5:0]  STATUS_IDX      = 6'h21;
    // Control one fields.
    localparam int          C1_START_BIT    = 7;
    localparam int          C1_ZERO_BIT     = 6;
    localparam int          C1_ONE_BIT      = 5;
    localparam int          C1_DISABLE_BIT  = 4;
    localparam int          C1_CHAN_LSB     = 0;
    localparam logic [7:0]  C1_RESET        = 8'h10;
    // Control two fields.
    localparam int          C2_LADDER_BIT   = 5;
    localparam int          C2_ONE_BIT      = 4;
    localparam int          C2_TIME_LSB     = 1;
    localparam logic [2:0]  C2_TIME_RESET   = 3'h0;
    // Status fields, then the result and channel reset values.
    localparam int          ST_EOC_BIT      = 5;
    localparam int          ST_BUSY_BIT     = 4;
    localparam logic [7:0]  RESULT_RESET    = 8'h00;
    localparam logic [3:0]  CHAN_RESET      = 4'h0;
    // Conversion times in high_freq_clock periods; clk is that clock.
    // The clock rate is held in 64 bits so the products behind the longer times cannot overflow.
    localparam longint      CLK_HZ          = 10_000_000;
    localparam int          FC_HZ           = 10_000_000;
    localparam int          CNT_W           = 11;
    localparam int          T_39_FC         = 39;
    localparam int          T_78_FC         = 78;
    localparam int          T_156_FC        = 156;
    localparam int          T_312_FC        = 312;
    localparam int          T_624_FC        = 624;
    localparam int          T_1248_FC       = 1248;
    localparam logic [CNT_W-1:0] LEN_39    = CNT_W'((T_39_FC * CLK_HZ + FC_HZ - 1) / FC_HZ);
    localparam logic [CNT_W-1:0] LEN_78    = CNT_W'((T_78_FC * CLK_HZ + FC_HZ - 1) / FC_HZ);
    localparam logic [CNT_W-1:0] LEN_156   = CNT_W'((T_156_FC * CLK_HZ + FC_HZ - 1) / FC_HZ);
    localparam logic [CNT_W-1:0] LEN_312   = CNT_W'((T_312_FC * CLK_HZ + FC_HZ - 1) / FC_HZ);
    localparam logic [CNT_W-1:0] LEN_624   = CNT_W'((T_624_FC * CLK_HZ + FC_HZ - 1) / FC_HZ);
    localparam logic [CNT_W-1:0] LEN_1248  = CNT_W'((T_1248_FC * CLK_HZ + FC_HZ - 1) / FC_HZ);
    // Each result bit gets this many cycles of comparator settling.
    localparam int          STEP_CYCLES     = 4;
    localparam int          RES_W           = 8;
endpackage

// ===== hw/conv_if.sv
`timescale 1ns/1ps
interface conv_if;
    import adc_seq_pkg::*;
    logic             start;
    logic             abort;
    logic [2:0]       time_code;
    logic             done;
    logic [RES_W-1:0] result;
    modport ctl (output start, output abort, output time_code, input done, input result);
    modport seq (input start, input abort, input time_code, output done, output result);
endinterface

// ===== hw/conv_timer.sv
`timescale 1ns/1ps
module conv_timer
    import adc_seq_pkg::*;
(
    input  wire logic             clk,
    input  wire logic             rst_sync_n,
    conv_if.seq                   cv,
    input  wire logic             cmp_above,
    output logic      [RES_W-1:0] cmp_trial
);
    logic [CNT_W-1:0] cnt;
    logic [CNT_W-1:0] len;
    logic [CNT_W-1:0] len_q;
    logic [CNT_W-1:0] run_cycles;
    logic             active;
    logic [RES_W-1:0] sar;
    logic             cmp_meta;
    logic             cmp_sync;
    wire  logic       in_steps  = active && (cnt < CNT_W'(RES_W * STEP_CYCLES));
    wire  logic [2:0] bit_idx   = cnt[4:2];
    wire  logic       decide    = in_steps && (cnt[1:0] == 2'h0);
    wire  logic [RES_W-1:0] trial = sar | (RES_W'(1) << bit_idx);
    wire  logic [RES_W-1:0] next_sar = cmp_sync ? trial : sar;

    // time code lookup. Reserved codes fall back to the longest time.
    always_comb begin
        unique case (cv.time_code)
            3'h0:    len = LEN_39;
            3'h2:    len = LEN_78;
            3'h3:    len = LEN_156;
            3'h4:    len = LEN_312;
            3'h5:    len = LEN_624;
            default: len = LEN_1248;
        endcase
    end

    always_ff @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            cmp_meta <= 1'b0;
            cmp_sync <= 1'b0;
        end else begin
            cmp_meta <= cmp_above;
            cmp_sync <= cmp_meta;
        end
    end

    // count down the selected conversion time.
    always_ff @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            active     <= 1'b0;
            cnt        <= '0;
            len_q      <= '0;
            run_cycles <= '0;
            sar        <= '0;
            cv.done    <= 1'b0;
            cv.result  <= RESULT_RESET;
            cmp_trial  <= '0;
        end else begin
            cv.done   <= active && !cv.abort && (cnt == '0);
            cmp_trial <= (in_steps && !cv.abort) ? trial : '0;
            if (cv.abort) begin
                active <= 1'b0;
            end else if (cv.start) begin
                active     <= 1'b1;
                cnt        <= len - CNT_W'(1);
                len_q      <= len;
                run_cycles <= '0;
                sar        <= '0;
            end else if (active) begin
                run_cycles <= run_cycles + CNT_W'(1);
                cnt        <= cnt - CNT_W'(1);
                if (decide) begin
                    sar <= next_sar;
                end
                if (cnt == '0) begin
                    active    <= 1'b0;
                    cv.result <= next_sar;
                end
            end
        end
    end

    a_conv_length: assert property (@(posedge clk) disable iff (!rst_sync_n)
        cv.done |-> run_cycles == len_q) else $error("conversion ended early");
endmodule // conv_timer

// ===== hw/adc_conversion_sequencer.sv
// The APB register port is this design's own decision.
`timescale 1ns/1ps
module adc_conversion_sequencer
    import adc_seq_pkg::*;
(
    input  wire logic              clk,
    input  wire logic              rst_n,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [ADDR_W-1:0] paddr,
    input  wire logic [DATA_W-1:0] pwdata,
    output logic      [DATA_W-1:0] prdata,
    output logic                   pready,
    output logic                   pslverr,
    input  wire logic              low_power_mode,
    input  wire logic              cmp_above,
    output logic      [RES_W-1:0]  cmp_trial,
    output logic      [3:0]        channel_select_field,
    output logic                   analog_input_disable,
    output logic                   ladder_connected,
    output logic                   conversion_done_irq
);
    logic                rst_meta_n;
    logic                rst_sync_n;
    logic                ack;
    logic                conversion_start_bit;
    logic                ladder_connect_ctrl;
    logic                fixed_one_bit;
    logic [2:0]          time_code;
    logic [RES_W-1:0]    conversion_result_reg;
    logic                end_of_conversion_flag;
    logic                converter_busy_flag;
    logic [DATA_W-1:0]   next_prdata;

    conv_if cv ();

    // Reset is asserted at once and released through two flops.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_meta_n <= 1'b0;
            rst_sync_n <= 1'b0;
        end else begin
            rst_meta_n <= 1'b1;
            rst_sync_n <= rst_meta_n;
        end
    end

    // Each access takes one wait cycle so read data can come from a flop
    // that samples the flags at the same edge that performs the side effect.
    wire logic       access     = psel && penable && !ack;
    wire logic [5:0] reg_idx    = paddr[ADDR_W-1:2];
    wire logic       aligned    = (paddr[1:0] == 2'h0);
    wire logic       hit_c1     = aligned && (reg_idx == CTRL_ONE_IDX);
    wire logic       hit_c2     = aligned && (reg_idx == CTRL_TWO_IDX);
    wire logic       hit_res    = aligned && (reg_idx == RESULT_IDX);
    wire logic       hit_st     = aligned && (reg_idx == STATUS_IDX);
    wire logic       mapped     = hit_c1 || hit_c2 || hit_res || hit_st;
    wire logic       wr_c1      = access && pwrite && hit_c1;
    wire logic       wr_c2      = access && pwrite && hit_c2;
    wire logic       result_rd  = access && !pwrite && hit_res;
    wire logic       start_req  = wr_c1 && pwdata[C1_START_BIT];
    // a start written while busy is ignored rather than corrupting a run.
    wire logic       start_take = start_req && !converter_busy_flag && !low_power_mode;

    assign pready  = ack;
    assign pslverr = ack && !mapped;

    always_ff @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            ack <= 1'b0;
        end else begin
            ack <= access;
        end
    end

    // only end and busy are driven; the other status bits read zero.
    // control two bits 7:6 read zero.
    always_comb begin
        next_prdata = '0;
        if (hit_c1) begin
            next_prdata[C1_ONE_BIT]     = fixed_one_bit;
            next_prdata[C1_DISABLE_BIT] = analog_input_disable;
            next_prdata[C1_CHAN_LSB +: 4] = channel_select_field;
        end else if (hit_c2) begin
            next_prdata[C2_LADDER_BIT]  = ladder_connect_ctrl;
            next_prdata[C2_ONE_BIT]     = 1'b1;
            next_prdata[C2_TIME_LSB +: 3] = time_code;
        end else if (hit_res) begin
            next_prdata[RES_W-1:0]      = conversion_result_reg;
        end else if (hit_st) begin
            next_prdata[ST_EOC_BIT]     = end_of_conversion_flag;
            next_prdata[ST_BUSY_BIT]    = converter_busy_flag;
        end
    end

    always_ff @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            prdata <= '0;
        end else if (access && !pwrite) begin
            prdata <= next_prdata;
        end
    end

    // low power forces both control registers to reset and blocks writes.
    always_ff @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            analog_input_disable <= C1_RESET[C1_DISABLE_BIT];
            fixed_one_bit        <= C1_RESET[C1_ONE_BIT];
            channel_select_field <= CHAN_RESET;
            ladder_connect_ctrl  <= 1'b0;
            time_code            <= C2_TIME_RESET;
        end else if (low_power_mode) begin
            analog_input_disable <= C1_RESET[C1_DISABLE_BIT];
            fixed_one_bit        <= C1_RESET[C1_ONE_BIT];
            channel_select_field <= CHAN_RESET;
            ladder_connect_ctrl  <= 1'b0;
            time_code            <= C2_TIME_RESET;
        end else begin
            // channel code drives the input multiplexer directly.
            if (wr_c1) begin
                analog_input_disable <= pwdata[C1_DISABLE_BIT];
                fixed_one_bit        <= pwdata[C1_ONE_BIT];
                channel_select_field <= pwdata[C1_CHAN_LSB +: 4];
            end
            // time code is held for the timer.
            if (wr_c2) begin
                ladder_connect_ctrl <= pwdata[C2_LADDER_BIT];
                time_code           <= pwdata[C2_TIME_LSB +: 3];
            end
        end
    end

    // start is a one-cycle pulse, so the bit never reads back as one.
    always_ff @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            conversion_start_bit <= 1'b0;
        end else begin
            conversion_start_bit <= start_take;
        end
    end

    assign cv.start     = conversion_start_bit;
    assign cv.abort     = low_power_mode;
    assign cv.time_code = time_code;

    // busy follows the run; only a new start sets it again.
    always_ff @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            converter_busy_flag <= 1'b0;
        end else if (low_power_mode || cv.done) begin
            converter_busy_flag <= 1'b0;
        end else if (start_take) begin
            converter_busy_flag <= 1'b1;
        end
    end

    // result loads on completion and is discarded in low power.
    always_ff @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            conversion_result_reg <= RESULT_RESET;
        end else if (low_power_mode) begin
            conversion_result_reg <= RESULT_RESET;
        end else if (cv.done) begin
            conversion_result_reg <= cv.result;
        end
    end

    // completion sets the flag and wins over a same-cycle read or start clear; low power clears it.
    always_ff @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            end_of_conversion_flag <= 1'b0;
        end else if (cv.done && !low_power_mode) begin
            end_of_conversion_flag <= 1'b1;
        end else if (result_rd || start_take || low_power_mode) begin
            end_of_conversion_flag <= 1'b0;
        end
    end

    // one-cycle request, raised on the same edge as the flag.
    always_ff @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            conversion_done_irq <= 1'b0;
        end else begin
            conversion_done_irq <= cv.done && !low_power_mode;
        end
    end

    // the ladder stays off in low power whatever the control says.
    assign ladder_connected = !low_power_mode && (ladder_connect_ctrl || converter_busy_flag);

    conv_timer u_timer (
        .clk        (clk),
        .rst_sync_n (rst_sync_n),
        .cv         (cv),
        .cmp_above  (cmp_above),
        .cmp_trial  (cmp_trial)
    );

    a_start_sets_busy: assert property (@(posedge clk) disable iff (!rst_sync_n)
        start_take |=> converter_busy_flag && cv.start) else $error("busy not set on start");

    a_done_loads_result: assert property (@(posedge clk) disable iff (!rst_sync_n)
        cv.done && !low_power_mode |=> conversion_result_reg == $past(cv.result)
        && end_of_conversion_flag && conversion_done_irq) else $error("completion incomplete");

    a_irq_single_pulse: assert property (@(posedge clk) disable iff (!rst_sync_n)
        conversion_done_irq |-> end_of_conversion_flag ##1 !conversion_done_irq)
        else $error("interrupt not a single pulse");

    a_read_clears_end: assert property (@(posedge clk) disable iff (!rst_sync_n)
        result_rd && !cv.done |=> !end_of_conversion_flag) else $error("read left end flag");

    a_restart_keeps_result: assert property (@(posedge clk) disable iff (!rst_sync_n)
        start_take && !cv.done |=> !end_of_conversion_flag
        && $stable(conversion_result_reg)) else $error("restart handling wrong");

    a_low_power_reset: assert property (@(posedge clk) disable iff (!rst_sync_n)
        low_power_mode |=> time_code == C2_TIME_RESET && !ladder_connect_ctrl
        && channel_select_field == CHAN_RESET && !converter_busy_flag)
        else $error("low power did not reset controls");

    a_no_auto_resume: assert property (@(posedge clk) disable iff (!rst_sync_n)
        !converter_busy_flag && !start_take |=> !converter_busy_flag)
        else $error("conversion resumed by itself");

    a_ladder_off_sleep: assert property (@(posedge clk) disable iff (!rst_sync_n)
        low_power_mode |-> !ladder_connected) else $error("ladder on in low power");

    a_start_self_clear: assert property (@(posedge clk) disable iff (!rst_sync_n)
        cv.start |=> !cv.start) else $error("start bit stuck");

    a_status_reserved: assert property (@(posedge clk) disable iff (!rst_sync_n)
        ack && !pwrite && hit_st |-> prdata[7:6] == 2'h0 && prdata[3:0] == 4'h0)
        else $error("status spare bits driven");

    a_eoc_rise_done: assert property (@(posedge clk) disable iff (!rst_sync_n)
        $rose(end_of_conversion_flag)
        |-> $past(cv.done))
        else $error("end flag set without completion");

    a_irq_after_done: assert property (@(posedge clk) disable iff (!rst_sync_n)
        conversion_done_irq
        |-> $past(cv.done) && !$past(low_power_mode))
        else $error("interrupt without completion");

    a_busy_rise_start: assert property (@(posedge clk) disable iff (!rst_sync_n)
        $rose(converter_busy_flag)
        |-> cv.start)
        else $error("busy rose without a start");

    a_busy_with_start: assert property (@(posedge clk) disable iff (!rst_sync_n)
        cv.start
        |-> converter_busy_flag)
        else $error("start pulse without busy");

    a_busy_clear_done: assert property (@(posedge clk) disable iff (!rst_sync_n)
        cv.done
        |=> !converter_busy_flag)
        else $error("busy left set after completion");

    a_result_steady: assert property (@(posedge clk) disable iff (!rst_sync_n)
        !cv.done && !low_power_mode
        |=> $stable(conversion_result_reg))
        else $error("result changed without completion");

    a_result_discard: assert property (@(posedge clk) disable iff (!rst_sync_n)
        low_power_mode
        |=> conversion_result_reg == RESULT_RESET)
        else $error("result kept in low power");

    a_end_clear_sleep: assert property (@(posedge clk) disable iff (!rst_sync_n)
        low_power_mode
        |=> !end_of_conversion_flag)
        else $error("end flag kept in low power");

    a_disable_sleep: assert property (@(posedge clk) disable iff (!rst_sync_n)
        low_power_mode
        |=> analog_input_disable == C1_RESET[C1_DISABLE_BIT] && fixed_one_bit == C1_RESET[C1_ONE_BIT])
        else $error("control one not reset in low power");

    a_no_irq_sleep: assert property (@(posedge clk) disable iff (!rst_sync_n)
        low_power_mode
        |=> !conversion_done_irq)
        else $error("interrupt raised in low power");

    a_start_busy_ignored: assert property (@(posedge clk) disable iff (!rst_sync_n)
        start_req && converter_busy_flag
        |=> !cv.start)
        else $error("restart accepted while busy");

    a_no_start_sleep: assert property (@(posedge clk) disable iff (!rst_sync_n)
        low_power_mode
        |=> !cv.start)
        else $error("conversion started in low power");

    a_result_read_data: assert property (@(posedge clk) disable iff (!rst_sync_n)
        ack && !pwrite && hit_res
        |-> prdata[RES_W-1:0] == $past(conversion_result_reg) && prdata[DATA_W-1:RES_W] == '0)
        else $error("result read data wrong");

    a_status_flags: assert property (@(posedge clk) disable iff (!rst_sync_n)
        ack && !pwrite && hit_st
        |-> prdata[ST_EOC_BIT] == $past(end_of_conversion_flag) && prdata[ST_BUSY_BIT] == $past(converter_busy_flag))
        else $error("status flags read wrong");

    a_ctrl_two_spare: assert property (@(posedge clk) disable iff (!rst_sync_n)
        ack && !pwrite && hit_c2
        |-> prdata[7:6] == 2'h0)
        else $error("control two spare bits driven");

    a_start_reads_zero: assert property (@(posedge clk) disable iff (!rst_sync_n)
        ack && !pwrite && hit_c1
        |-> !prdata[C1_START_BIT])
        else $error("start bit read back as one");

    a_ready_one_wait: assert property (@(posedge clk) disable iff (!rst_sync_n)
        psel && penable && !pready
        |=> pready)
        else $error("ready not given after one wait");

    a_ready_one_cycle: assert property (@(posedge clk) disable iff (!rst_sync_n)
        pready
        |=> !pready)
        else $error("ready held too long");

    a_trial_idle: assert property (@(posedge clk) disable iff (!rst_sync_n)
        !converter_busy_flag
        |-> cmp_trial == '0)
        else $error("trial code driven while idle");
endmodule // adc_conversion_sequencer

// ===== verif/adc_conversion_sequencer_test.sv
`timescale 1ns/1ps
module adc_conversion_sequencer_test;
    import adc_seq_pkg::*;
    logic              clk, rst_n, psel, penable, pwrite, low_power_mode, cmp_above;
    logic [ADDR_W-1:0] paddr;
    logic [DATA_W-1:0] pwdata, prdata, rd;
    logic              pready, pslverr, err, ain_dis, ladder, irq;
    logic [RES_W-1:0]  cmp_trial, ain, m_res;
    logic [3:0]        chan;
    logic              m_eoc;
    int                error_cnt = 0;
    int                compares = 0;
    int                lens[8] = '{39, 1248, 78, 156, 312, 624, 1248, 1248};

    adc_conversion_sequencer dut_u (.clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .low_power_mode(low_power_mode), .cmp_above(cmp_above),
        .cmp_trial(cmp_trial), .channel_select_field(chan), .analog_input_disable(ain_dis),
        .ladder_connected(ladder), .conversion_done_irq(irq));

    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    // The comparator is analog: it follows the trial code within the cycle.
    assign cmp_above = (ain >= cmp_trial);

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            error_cnt++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic final_report();
        $display("checks %0d mismatches %0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask

    // One APB transfer; the request stands until pready is sampled high.
    task automatic apb(input logic wr, input logic [5:0] idx, input logic [7:0] wd);
        int n = 0;
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= {idx, 2'b00};
        pwdata <= {24'h0, wd};
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n >= 20) check("pready", 32'h0, 32'h1);
    endtask

    task automatic status(input logic busy);
        apb(1'b0, STATUS_IDX, 8'h00);
        check("status", 32'({rd[ST_EOC_BIT], rd[ST_BUSY_BIT]}), 32'({m_eoc, busy}));
    endtask

    // Start a conversion; cnt counts edges from the access edge of the start write.
    // The interrupt rises L + 2 edges later and is sampled at the edge after that.
    task automatic run_conv(input int code, input bit rd_res);
        logic [3:0] ch;
        logic       lad;
        int         cnt;
        ch = 4'($urandom_range(7));
        lad = (code == 0);
        apb(1'b1, CTRL_TWO_IDX, {2'b00, lad, 1'b1, code[2:0], 1'b0});
        ain <= 8'($urandom);
        apb(1'b1, CTRL_ONE_IDX, {4'h a, ch});
        m_eoc = 1'b0;
        status(1'b1);
        check("chan", 32'(chan), 32'(ch));
        check("ladder busy", 32'(ladder), 32'h1);
        apb(1'b0, RESULT_IDX, 8'h00);
        check("old result", rd, 32'(m_res));
        apb(1'b0, CTRL_ONE_IDX, 8'h00);
        check("ctrl one", rd, 32'({4'h2, ch}));
        cnt = 13;
        do begin
            @(posedge clk);
            cnt++;
        end while (irq !== 1'b1 && cnt < 1400);
        check("conv length", 32'(cnt), 32'(lens[code] + 3));
        m_res = ain;
        m_eoc = 1'b1;
        @(posedge clk);
        check("irq pulse", 32'(irq), 32'h0);
        check("ladder idle", 32'(ladder), 32'(lad));
        status(1'b0);
        if (rd_res) begin
            apb(1'b0, RESULT_IDX, 8'h00);
            check("result", rd, 32'(m_res));
            m_eoc = 1'b0;
            status(1'b0);
        end
    endtask

    initial begin
        #(30000 * 100);
        error_cnt++;
        final_report();
    end

    initial begin
        int hits;
        rst_n = 1'b0;
        {psel, penable, pwrite, low_power_mode} = 4'h0;
        paddr = '0;
        pwdata = '0;
        ain = 8'h00;
        m_res = 8'h00;
        m_eoc = 1'b0;
        void'($urandom(32'h2147870c));
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge clk);
        check("reset pins", 32'({ain_dis, chan, ladder, irq}), 32'h40);
        apb(1'b0, CTRL_ONE_IDX, 8'h00);
        check("ctrl one reset", rd, 32'(C1_RESET));
        apb(1'b0, CTRL_TWO_IDX, 8'h00);
        check("ctrl two reset", 32'(rd[5:0]), 32'h10);
        apb(1'b1, RESULT_IDX, 8'h55);
        apb(1'b0, RESULT_IDX, 8'h00);
        check("result reset", rd, 32'(RESULT_RESET));
        status(1'b0);
        apb(1'b0, 6'h01, 8'h00);
        check("unmapped", 32'(err), 32'h1);
        $display("test reset done");
        for (int c = 0; c < 8; c++) run_conv(c, c[0]);
        $display("test conversions done");
        apb(1'b1, CTRL_TWO_IDX, 8'h3c);
        apb(1'b1, CTRL_ONE_IDX, 8'ha3);
        repeat (50) @(posedge clk);
        low_power_mode <= 1'b1;
        apb(1'b1, CTRL_ONE_IDX, 8'ha5);
        m_eoc = 1'b0;
        status(1'b0);
        check("ladder off", 32'(ladder), 32'h0);
        apb(1'b0, CTRL_ONE_IDX, 8'h00);
        check("ctrl one abort", rd, 32'(C1_RESET));
        apb(1'b0, CTRL_TWO_IDX, 8'h00);
        check("ctrl two abort", 32'(rd[5:0]), 32'h10);
        apb(1'b0, RESULT_IDX, 8'h00);
        check("result abort", rd, 32'h0);
        low_power_mode <= 1'b0;
        hits = 0;
        repeat (1400) begin
            @(posedge clk);
            if (irq !== 1'b0) hits++;
        end
        check("no resume", 32'(hits), 32'h0);
        status(1'b0);
        $display("test low power done");
        final_report();
    end
endmodule // adc_conversion_sequencer_test
